// *** pss_state_eval.sv ***
// State word decoder of the power step machine, with Avalon-MM slave.
// Assumes synchronous inputs on clk_sys and software loading the word
// low half first; the write of the high half counts as state entry.
//
// Contract
// - Even bits 20-28 pick input fault level
// - Odd bits 21-29 unmask input monitoring
// - Bit 30 unmasks warning; fault on one
// - Bits 31-34 select dwell limit length
// - Bits 35-38 select advance condition source
// - Bit 39 inverts advance polarity
// - Bits 40-43 set advance hold delay
// - Ping code sends ping to delay address
// - Pong code waits ping, answers same address
// - Monitor fault jumps to bits 44-49
// - Dwell expiry jumps to bits 50-55
// - Met advance jumps to bits 56-61
// - Round robin is bit 62 OR global
// - Bit 63 broadcasts on local advance exit
// - Code zero: no dwell limit, no delay
// - Codes 14 and 15 are ping, pong
// - Code 12 waits software jump command
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
`timescale 1ns/1ps
`include "pss_map.svh"

module pss_state_eval #(
	parameter int TICK_CYCLES = `PSS_TICK_NS / `PSS_CLK_NS,
	parameter int CNT_W       = `PSS_CNT_W
) (
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	input  wire pss_pkg::pss_sense_t  sense,
	input  wire logic                 link_rx_ping,
	input  wire logic [3:0]           link_rx_addr,
	input  wire logic                 link_tx_ready,
	output pss_pkg::pss_link_tx_t     link_tx,
	output pss_pkg::pss_jump_t        jump,
	output logic                      round_robin_en
);

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (TICK_CYCLES < 1 ||
	    CNT_W < $clog2(4001 * TICK_CYCLES + 1)) begin : g_bad_param
		$error("pss_state_eval: TICK_CYCLES or CNT_W out of range.");
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [63:0]              word_ff;
	logic                     glob_rr_ff;
	logic                     jump_cmd_ff;
	logic                     wait_ff;
	logic [31:0]              rdata_ff;
	pss_pkg::pss_state_t      state_ff;
	pss_pkg::pss_state_t      nxt_state;
	pss_pkg::pss_link_tx_t    tx_ff;
	pss_pkg::pss_jump_t       jump_ff;
	pss_pkg::pss_cause_t      last_cause_ff;
	logic [5:0]               last_target_ff;
	logic                     ping_sent_ff;
	logic                     ping_heard_ff;
	logic                     pong_sent_ff;
	logic                     rr_ff;
	logic                     settle_ff;
	logic [CNT_W-1:0]         dwell_cnt_ff;
	logic [CNT_W-1:0]         adv_cnt_ff;
	logic [11:0]              dwell_ticks;
	logic [11:0]              adv_ticks;
	logic [CNT_W-1:0]         dwell_limit;
	logic [CNT_W-1:0]         adv_limit;
	logic [4:0]               dfi_hit;
	logic [15:0]              src_all;
	logic                     wr_take;
	logic                     rd_take;
	logic                     entry;
	logic                     running;
	logic                     mon_fault;
	logic                     dwell_exp;
	logic                     adv_true;
	logic                     adv_go;
	logic                     leave;
	logic                     tx_done;
	logic                     bcast_go;
	logic [3:0]               dwell_code;
	logic [3:0]               adv_sel;
	logic [3:0]               adv_dly;
	logic [31:0]              status;
	logic [31:0]              ctrl_rd;

	function automatic logic [31:0] pss_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ****************************************************************
	// Avalon-MM slave
	// ****************************************************************
	// One wait state on every access keeps read data registered.
	assign rd_take = avs_read & wait_ff;
	assign wr_take = avs_write & ~wait_ff;
	assign entry   = wr_take && (avs_address == `PSS_OFS_WORD_HI);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wait_ff <= 1'b1;
		end else if (wait_ff) begin
			wait_ff <= ~(avs_read | avs_write);
		end else begin
			wait_ff <= 1'b1;
		end
	end

	assign ctrl_rd = {29'h0, jump_cmd_ff, glob_rr_ff, 1'b0};
	assign status  = {16'h0, 2'h0, last_target_ff, last_cause_ff,
	                  adv_true, mon_fault, 1'b0, state_ff};

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_ff <= 32'h0;
		end else if (rd_take) begin
			case (avs_address)
				`PSS_OFS_WORD_LO: rdata_ff <= word_ff[31:0];
				`PSS_OFS_WORD_HI: rdata_ff <= word_ff[63:32];
				`PSS_OFS_CTRL:    rdata_ff <= ctrl_rd;
				`PSS_OFS_STATUS:  rdata_ff <= status;
				default:          rdata_ff <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			word_ff <= `PSS_WORD_RST;
		end else if (wr_take && avs_address == `PSS_OFS_WORD_LO) begin
			word_ff[31:0] <= pss_merge(word_ff[31:0], avs_writedata,
			                           avs_byteenable);
		end else if (entry) begin
			word_ff[63:32] <= pss_merge(word_ff[63:32], avs_writedata,
			                            avs_byteenable);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			glob_rr_ff <= 1'b0;
		end else if (wr_take && avs_address == `PSS_OFS_CTRL &&
		             avs_byteenable[0]) begin
			glob_rr_ff <= avs_writedata[`PSS_CTRL_RR];
		end
	end

	// A new command written in the leaving cycle survives the clear.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			jump_cmd_ff <= 1'b0;
		end else if (wr_take && avs_address == `PSS_OFS_CTRL &&
		             avs_byteenable[0] && avs_writedata[`PSS_CTRL_JUMP]) begin
			jump_cmd_ff <= 1'b1;
		end else if (leave) begin
			jump_cmd_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// Field decode and monitor
	// ****************************************************************
	assign dwell_code = word_ff[`PSS_B_DWELL +: 4];
	assign adv_sel    = word_ff[`PSS_B_ADV_SEL +: 4];
	assign adv_dly    = word_ff[`PSS_B_ADV_DLY +: 4];
	assign running    = (state_ff == pss_pkg::ST_RUN) && !settle_ff;

	for (genvar i = 0; i < 5; i++) begin : g_dfi
		assign dfi_hit[i] = word_ff[`PSS_B_DFI_EN + 2*i] &&
			(sense.dual_function_input[i] ==
			 word_ff[`PSS_B_DFI_POL + 2*i]);
	end

	assign mon_fault = (|dfi_hit) ||
		(word_ff[`PSS_B_WARN_EN] && sense.warning);

	// ****************************************************************
	// Advance condition
	// ****************************************************************
	assign src_all = {pong_sent_ff, ping_sent_ff, 1'b0, jump_cmd_ff,
	                  sense.warning, sense.dual_function_input,
	                  sense.vh, sense.vp, 1'b0};
	assign adv_true = src_all[adv_sel] ^ word_ff[`PSS_B_ADV_POL];

	pss_delay_rom u_dwell_rom (
		.clk_sys (clk_sys),
		.reset   (reset),
		.code    (dwell_code),
		.ticks   (dwell_ticks)
	);

	pss_delay_rom u_adv_rom (
		.clk_sys (clk_sys),
		.reset   (reset),
		.code    (adv_dly),
		.ticks   (adv_ticks)
	);

	assign dwell_limit = CNT_W'(dwell_ticks) * CNT_W'(TICK_CYCLES);
	assign adv_limit   = CNT_W'(adv_ticks) * CNT_W'(TICK_CYCLES);

	// The delay field doubles as a link address for ping and pong.
	assign dwell_exp = (dwell_code != `PSS_CODE_OFF) &&
		(dwell_cnt_ff >= dwell_limit);
	assign adv_go = adv_true && ((adv_dly == `PSS_CODE_OFF) ||
		adv_sel == `PSS_ADV_PING || adv_sel == `PSS_ADV_PONG ||
		adv_cnt_ff >= adv_limit);

	assign leave    = running && !entry &&
		(mon_fault || dwell_exp || adv_go);
	assign bcast_go = running && !entry && !mon_fault && !dwell_exp &&
		adv_go && word_ff[`PSS_B_BCAST];
	assign tx_done  = tx_ff.valid && link_tx_ready;

	// ****************************************************************
	// Counters
	// ****************************************************************
	// Delay limits lag entry by one edge, so running waits for them.
	always_ff @(posedge clk_sys) begin
		settle_ff <= entry && !reset;
	end

	always_ff @(posedge clk_sys) begin
		if (reset || entry || !running) begin
			dwell_cnt_ff <= '0;
		end else if (dwell_cnt_ff < dwell_limit) begin
			dwell_cnt_ff <= dwell_cnt_ff + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || entry || !running || !adv_true) begin
			adv_cnt_ff <= '0;
		end else if (adv_cnt_ff < adv_limit) begin
			adv_cnt_ff <= adv_cnt_ff + CNT_W'(1);
		end
	end

	// ****************************************************************
	// State machine
	// ****************************************************************
	always_comb begin
		case (state_ff)
			pss_pkg::ST_IDLE: nxt_state = pss_pkg::ST_IDLE;
			pss_pkg::ST_RUN: begin
				if (bcast_go) begin
					nxt_state = pss_pkg::ST_HOLD;
				end else if (leave) begin
					nxt_state = pss_pkg::ST_IDLE;
				end else begin
					nxt_state = pss_pkg::ST_RUN;
				end
			end
			pss_pkg::ST_HOLD: begin
				nxt_state = tx_done ? pss_pkg::ST_IDLE : pss_pkg::ST_HOLD;
			end
			default: nxt_state = pss_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_ff <= pss_pkg::ST_IDLE;
		end else if (entry) begin
			state_ff <= pss_pkg::ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Monitor faults outrank expiry, which outranks a met advance.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			jump_ff        <= '0;
			last_cause_ff  <= pss_pkg::CAUSE_NONE;
			last_target_ff <= 6'h0;
		end else if (leave) begin
			jump_ff.valid <= 1'b1;
			if (mon_fault) begin
				jump_ff.cause  <= pss_pkg::CAUSE_MON;
				jump_ff.target <= word_ff[`PSS_B_MON_TGT +: 6];
				last_cause_ff  <= pss_pkg::CAUSE_MON;
				last_target_ff <= word_ff[`PSS_B_MON_TGT +: 6];
			end else if (dwell_exp) begin
				jump_ff.cause  <= pss_pkg::CAUSE_DWELL;
				jump_ff.target <= word_ff[`PSS_B_EXP_TGT +: 6];
				last_cause_ff  <= pss_pkg::CAUSE_DWELL;
				last_target_ff <= word_ff[`PSS_B_EXP_TGT +: 6];
			end else begin
				jump_ff.cause  <= pss_pkg::CAUSE_ADV;
				jump_ff.target <= word_ff[`PSS_B_ADV_TGT +: 6];
				last_cause_ff  <= pss_pkg::CAUSE_ADV;
				last_target_ff <= word_ff[`PSS_B_ADV_TGT +: 6];
			end
		end else begin
			jump_ff.valid <= 1'b0;
		end
	end

	// ****************************************************************
	// Interchip link handshake
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (reset || entry) begin
			ping_sent_ff  <= 1'b0;
			ping_heard_ff <= 1'b0;
			pong_sent_ff  <= 1'b0;
		end else begin
			if (tx_done && tx_ff.kind == pss_pkg::TX_PING) begin
				ping_sent_ff <= 1'b1;
			end
			if (running && adv_sel == `PSS_ADV_PONG && link_rx_ping &&
			    link_rx_addr == adv_dly) begin
				ping_heard_ff <= 1'b1;
			end
			if (tx_done && tx_ff.kind == pss_pkg::TX_PONG) begin
				pong_sent_ff <= 1'b1;
			end
		end
	end

	// A broadcast at exit waits for the link before the block idles.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_ff <= '0;
		end else if (tx_done) begin
			tx_ff <= '0;
		end else if (!tx_ff.valid) begin
			if (bcast_go) begin
				tx_ff <= {1'b1, pss_pkg::TX_BCAST, 4'h0};
			end else if (running && !entry && adv_sel == `PSS_ADV_PING &&
			             !ping_sent_ff) begin
				tx_ff <= {1'b1, pss_pkg::TX_PING, adv_dly};
			end else if (running && !entry && ping_heard_ff &&
			             !pong_sent_ff) begin
				tx_ff <= {1'b1, pss_pkg::TX_PONG, adv_dly};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rr_ff <= 1'b0;
		end else begin
			rr_ff <= word_ff[`PSS_B_RR] | glob_rr_ff;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign link_tx         = tx_ff;
	assign jump            = jump_ff;
	assign round_robin_en  = rr_ff;

endmodule // pss_state_eval

`default_nettype wire

// *** pss_map.svh ***
// Constants for the power step machine state word decoder.
// Assumes a 50 MHz clk_sys and byte addresses on the register bus.
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define PSS_CLK_NS        20
`define PSS_TICK_NS       100000
`define PSS_CNT_W         25

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define PSS_ADDR_W        4
`define PSS_OFS_WORD_LO   4'h0
`define PSS_OFS_WORD_HI   4'h4
`define PSS_OFS_CTRL      4'h8
`define PSS_OFS_STATUS    4'hC
`define PSS_CTRL_RR       1
`define PSS_CTRL_JUMP     2
`define PSS_WORD_RST      64'h0000_0000_0000_0000

// ****************************************************************
// State word bit positions
// ****************************************************************
`define PSS_B_DFI_POL     20
`define PSS_B_DFI_EN      21
`define PSS_B_WARN_EN     30
`define PSS_B_DWELL       31
`define PSS_B_ADV_SEL     35
`define PSS_B_ADV_POL     39
`define PSS_B_ADV_DLY     40
`define PSS_B_MON_TGT     44
`define PSS_B_EXP_TGT     50
`define PSS_B_ADV_TGT     56
`define PSS_B_RR          62
`define PSS_B_BCAST       63

// ****************************************************************
// Advance condition codes
// ****************************************************************
`define PSS_ADV_SMBUS     4'hC
`define PSS_ADV_PING      4'hE
`define PSS_ADV_PONG      4'hF
`define PSS_CODE_OFF      4'h0

// ****************************************************************
// Delay table, in units of one tick
// ****************************************************************
`define PSS_DLY_0         12'h000
`define PSS_DLY_1         12'h001
`define PSS_DLY_2         12'h002
`define PSS_DLY_3         12'h004
`define PSS_DLY_4         12'h007
`define PSS_DLY_5         12'h00A
`define PSS_DLY_6         12'h014
`define PSS_DLY_7         12'h028
`define PSS_DLY_8         12'h046
`define PSS_DLY_9         12'h064
`define PSS_DLY_10        12'h0C8
`define PSS_DLY_11        12'h190
`define PSS_DLY_12        12'h2BC
`define PSS_DLY_13        12'h3E8
`define PSS_DLY_14        12'h7D0
`define PSS_DLY_15        12'hFA0

`endif

// *** pss_pkg.sv ***
// Types shared by the state word decoder, its checker and its bench.
// Assumes pss_map.svh supplies every numeric constant.
`default_nettype none

package pss_pkg;

	// ****************************************************************
	// Enumerations
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_HOLD = 3'h4
	} pss_state_t;

	typedef enum logic [1:0] {
		CAUSE_NONE  = 2'h0,
		CAUSE_MON   = 2'h1,
		CAUSE_DWELL = 2'h2,
		CAUSE_ADV   = 2'h3
	} pss_cause_t;

	typedef enum logic [1:0] {
		TX_NONE  = 2'h0,
		TX_PING  = 2'h1,
		TX_PONG  = 2'h2,
		TX_BCAST = 2'h3
	} pss_tx_kind_t;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic       warning;
		logic [4:0] dual_function_input;
		logic       vh;
		logic [3:0] vp;
	} pss_sense_t;

	typedef struct packed {
		logic         valid;
		pss_tx_kind_t kind;
		logic [3:0]   addr;
	} pss_link_tx_t;

	typedef struct packed {
		logic       valid;
		pss_cause_t cause;
		logic [5:0] target;
	} pss_jump_t;

endpackage

`default_nettype wire

// *** pss_delay_rom.sv ***
// Delay table: turns a 4-bit dwell or advance code into a tick count.
// Assumes the code is held steady; the count appears one edge later.
`default_nettype none
`timescale 1ns/1ps
`include "pss_map.svh"

module pss_delay_rom (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [3:0]  code,
	output logic      [11:0] ticks
);

	logic [11:0] ticks_ff;
	logic [11:0] nxt_ticks;

	always_comb begin
		case (code)
			4'h0:    nxt_ticks = `PSS_DLY_0;
			4'h1:    nxt_ticks = `PSS_DLY_1;
			4'h2:    nxt_ticks = `PSS_DLY_2;
			4'h3:    nxt_ticks = `PSS_DLY_3;
			4'h4:    nxt_ticks = `PSS_DLY_4;
			4'h5:    nxt_ticks = `PSS_DLY_5;
			4'h6:    nxt_ticks = `PSS_DLY_6;
			4'h7:    nxt_ticks = `PSS_DLY_7;
			4'h8:    nxt_ticks = `PSS_DLY_8;
			4'h9:    nxt_ticks = `PSS_DLY_9;
			4'hA:    nxt_ticks = `PSS_DLY_10;
			4'hB:    nxt_ticks = `PSS_DLY_11;
			4'hC:    nxt_ticks = `PSS_DLY_12;
			4'hD:    nxt_ticks = `PSS_DLY_13;
			4'hE:    nxt_ticks = `PSS_DLY_14;
			default: nxt_ticks = `PSS_DLY_15;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ticks_ff <= `PSS_DLY_0;
		end else begin
			ticks_ff <= nxt_ticks;
		end
	end

	assign ticks = ticks_ff;

endmodule // pss_delay_rom

`default_nettype wire

// *** pss_link_peer.sv ***
// Far side of the decoder: a peer on the link.
// Assumes the bench commands each ping; ready is random when slow is set.
`timescale 1ns/1ps
`default_nettype none
module pss_link_peer (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       send_ping,
	input  wire logic [3:0] send_addr,
	input  wire logic       slow,
	output logic            link_tx_ready,
	output logic            link_rx_ping,
	output logic [3:0]      link_rx_addr
);
	// A slow peer stalls the sender for a few cycles.
	always_ff @(posedge clk_sys) begin
		if (reset)
			link_tx_ready <= 1'h0;
		else
			link_tx_ready <= !slow || ($urandom_range(3) == 0);
	end

	// Between pings the address toggles, so stale matches show.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			link_rx_ping <= 1'h0;
			link_rx_addr <= 4'h0;
		end else begin
			link_rx_ping <= send_ping;
			link_rx_addr <= send_ping ? send_addr : ~link_rx_addr;
		end
	end
endmodule // pss_link_peer
`default_nettype wire

// *** pss_state_eval_asserts.sv ***
// Checker for the state word decoder, bound to pss_state_eval.
// Assumes one clock domain and the synchronous reset of the design.
`timescale 1ns/1ps
`default_nettype none
module pss_state_eval_asserts #(
	parameter int TICK_CYCLES = 5000,
	parameter int CNT_W       = 25
) (
	input wire logic                  clk_sys,
	input wire logic                  reset,
	input wire logic [3:0]            avs_address,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic                  avs_waitrequest,
	input wire logic                  link_rx_ping,
	input wire logic [3:0]            link_rx_addr,
	input wire logic                  link_tx_ready,
	input wire pss_pkg::pss_link_tx_t link_tx,
	input wire pss_pkg::pss_jump_t    jump,
	input wire logic                  round_robin_en
);
	// Cycles since the last high word write, which is state entry.
	logic [CNT_W-1:0] since_ff;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	always_ff @(posedge clk_sys) begin
		if (reset || (avs_write && !avs_waitrequest && avs_address == 4'h4))
			since_ff <= '0;
		else if (since_ff != '1)
			since_ff <= since_ff + 1'h1;
	end

	a_bus_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop");
	a_bus_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_reset_quiet: assert property ($fell(reset) |->
		avs_waitrequest && !jump.valid && !link_tx.valid)
		else $error("outputs busy after reset");
	a_jump_once: assert property (
		jump.valid |-> jump.cause != pss_pkg::CAUSE_NONE ##1 !jump.valid [*3])
		else $error("jump without cause or repeated");
	a_dwell_floor: assert property (
		jump.valid && jump.cause == pss_pkg::CAUSE_DWELL
		|-> since_ff >= TICK_CYCLES - 1)
		else $error("dwell expiry too early");
	a_tx_held: assert property (
		link_tx.valid && !link_tx_ready |=> $stable(link_tx))
		else $error("link message changed before acceptance");
	a_tx_drop: assert property (
		link_tx.valid && link_tx_ready |=> !link_tx.valid)
		else $error("link message repeated");
	a_pong_reply: assert property (
		$rose(link_tx.valid) && link_tx.kind == pss_pkg::TX_PONG |->
		($past(link_rx_ping) && $past(link_rx_addr) == link_tx.addr) ||
		($past(link_rx_ping, 2) && $past(link_rx_addr, 2) == link_tx.addr) ||
		($past(link_rx_ping, 3) && $past(link_rx_addr, 3) == link_tx.addr))
		else $error("reply without matching ping");
	a_bcast_adv: assert property (
		$rose(link_tx.valid) && link_tx.kind == pss_pkg::TX_BCAST |->
		jump.valid && jump.cause == pss_pkg::CAUSE_ADV)
		else $error("broadcast without advance exit");
	a_rr_by_write: assert property (
		$changed(round_robin_en) |->
		$past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
		else $error("round robin changed without a write");
endmodule // pss_state_eval_asserts

bind pss_state_eval pss_state_eval_asserts #(
	.TICK_CYCLES(TICK_CYCLES),
	.CNT_W(CNT_W)
) u_asserts (
	.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .link_rx_ping(link_rx_ping),
	.link_rx_addr(link_rx_addr), .link_tx_ready(link_tx_ready),
	.link_tx(link_tx), .jump(jump), .round_robin_en(round_robin_en)
);
`default_nettype wire

// *** pss_state_eval_tb_top.sv ***
// Self-checking bench for the power step machine state word decoder.
// Assumes pss_pkg, the link peer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module pss_state_eval_tb_top;
	localparam int TICK = 2;
	logic clk_sys = 1'h0;
	logic reset = 1'h1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	pss_pkg::pss_sense_t sense = '0;
	logic send_ping = 1'h0;
	logic [3:0] send_addr = 4'h0;
	logic slow = 1'h0;
	logic link_rx_ping;
	logic [3:0] link_rx_addr;
	logic link_tx_ready;
	pss_pkg::pss_link_tx_t link_tx;
	pss_pkg::pss_jump_t jump;
	logic round_robin_en;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int entry = 0;
	int jump_cyc = 0;
	int tbl[4] = '{0, 1, 2, 4};
	logic [7:0] jq[$];
	logic [5:0] tq[$];

	always #10 clk_sys = ~clk_sys;

	pss_state_eval #(.TICK_CYCLES(TICK)) DUT (
		.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sense(sense), .link_rx_ping(link_rx_ping),
		.link_rx_addr(link_rx_addr), .link_tx_ready(link_tx_ready),
		.link_tx(link_tx), .jump(jump), .round_robin_en(round_robin_en)
	);
	pss_link_peer u_peer (
		.clk_sys(clk_sys), .reset(reset), .send_ping(send_ping),
		.send_addr(send_addr), .slow(slow), .link_tx_ready(link_tx_ready),
		.link_rx_ping(link_rx_ping), .link_rx_addr(link_rx_addr)
	);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// An unexpected jump or message compares against zero and fails.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (!reset && jump.valid === 1'h1) begin
			jump_cyc = cyc;
			if (jq.size() == 0)
				chk("jump", 8'h0, {jump.cause, jump.target});
			else
				chk("jump", jq.pop_front(), {jump.cause, jump.target});
		end
		if (!reset && link_tx.valid === 1'h1 && link_tx_ready === 1'h1) begin
			if (tq.size() == 0)
				chk("link", 6'h0, {link_tx.kind, link_tx.addr});
			else
				chk("link", tq.pop_front(), {link_tx.kind, link_tx.addr});
		end
	end

	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hF;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'h0) begin
			@(posedge clk_sys);
		end
		chk("waitrequest", 32'h0, avs_waitrequest);
		q = avs_readdata;
		if (wr && a == 4'h4)
			entry = cyc;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk_sys);
	endtask

	task automatic load(input logic [63:0] w);
		logic [31:0] q;
		bus(1'h1, 4'h0, w[31:0], q);
		bus(1'h1, 4'h4, w[63:32], q);
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (jq.size() + tq.size() != 0 && n < 500) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (4) @(posedge clk_sys);
		chk("pending", 32'h0, jq.size() + tq.size());
	endtask

	task automatic ping(input logic [3:0] a);
		send_addr <= a;
		send_ping <= 1'h1;
		@(posedge clk_sys);
		send_ping <= 1'h0;
		repeat (3) @(posedge clk_sys);
	endtask

	initial begin
		logic [31:0] q;
		logic [63:0] w;
		int k;
		k = $urandom(366);
		repeat (16) @(posedge clk_sys);
		reset <= 1'h0;
		@(posedge clk_sys);
		bus(1'h0, 4'h2, 32'h0, q);
		chk("unmapped", 32'h0, q);
		w = {$urandom, $urandom};
		bus(1'h1, 4'h0, w[31:0], q);
		bus(1'h0, 4'h0, 32'h0, q);
		chk("word_lo", w[31:0], q);
		// Warning is high but masked; only input k faults.
		for (k = 0; k < 5; k++) begin
			q = $urandom;
			w = 64'h0;
			w[20 + 2 * k] = q[0];
			w[21 + 2 * k] = 1'h1;
			w[49:44] = q[9:4];
			sense <= {1'h1, {5{!q[0]}}, q[14:10]};
			load(w);
			repeat (6) @(posedge clk_sys);
			jq.push_back({pss_pkg::CAUSE_MON, q[9:4]});
			sense[5 + k] <= q[0];
			drain();
		end
		w = 64'h0;
		w[30] = 1'h1;
		w[49:44] = 6'h2A;
		sense <= '0;
		load(w);
		repeat (20) @(posedge clk_sys);
		jq.push_back({pss_pkg::CAUSE_MON, 6'h2A});
		sense.warning <= 1'h1;
		drain();
		for (k = 1; k < 4; k++) begin
			w = 64'h0;
			w[34:31] = k[3:0];
			w[55:50] = 6'(k + 8);
			jq.push_back({pss_pkg::CAUSE_DWELL, 6'(k + 8)});
			load(w);
			drain();
			chk("dwell_time", 1'h1, (jump_cyc - entry) inside
				{[tbl[k] * TICK : tbl[k] * TICK + 3]});
		end
		for (k = 1; k < 12; k++) begin
			q = $urandom;
			w = 64'h0;
			w[38:35] = k[3:0];
			w[39] = q[0];
			w[41:40] = q[2:1];
			w[61:56] = q[9:4];
			sense <= {11{q[0]}};
			load(w);
			repeat (4) @(posedge clk_sys);
			jq.push_back({pss_pkg::CAUSE_ADV, q[9:4]});
			entry = cyc;
			sense[k - 1] <= !q[0];
			drain();
			chk("adv_time", 1'h1, (jump_cyc - entry) inside
				{[tbl[q[2:1]] * TICK : tbl[q[2:1]] * TICK + 4]});
		end
		// Software jump with polarity 0.
		w = 64'h0;
		w[38:35] = 4'hC;
		w[61:56] = 6'h15;
		load(w);
		repeat (6) @(posedge clk_sys);
		jq.push_back({pss_pkg::CAUSE_ADV, 6'h15});
		bus(1'h1, 4'h8, 32'h4, q);
		drain();
		w = 64'h0;
		w[21:20] = 2'h3;
		w[49:44] = 6'h11;
		w[38:35] = 4'h6;
		w[61:56] = 6'h22;
		sense <= '0;
		load(w);
		repeat (3) @(posedge clk_sys);
		jq.push_back({pss_pkg::CAUSE_MON, 6'h11});
		sense[5] <= 1'h1;
		drain();
		slow <= 1'h1;
		q = $urandom;
		w = 64'h0;
		w[38:35] = 4'hE;
		w[43:40] = q[3:0];
		w[61:56] = q[9:4];
		w[63] = 1'h1;
		tq.push_back({pss_pkg::TX_PING, q[3:0]});
		tq.push_back({pss_pkg::TX_BCAST, 4'h0});
		jq.push_back({pss_pkg::CAUSE_ADV, q[9:4]});
		load(w);
		drain();
		w[38:35] = 4'hF;
		w[63] = 1'h0;
		tq.push_back({pss_pkg::TX_PONG, q[3:0]});
		jq.push_back({pss_pkg::CAUSE_ADV, q[9:4]});
		load(w);
		ping(~q[3:0]);
		ping(q[3:0]);
		drain();
		slow <= 1'h0;
		w = 64'h0;
		w[62] = 1'h1;
		load(w);
		repeat (3) @(posedge clk_sys);
		chk("round_robin", 1'h1, round_robin_en);
		load(64'h0);
		bus(1'h1, 4'h8, 32'h2, q);
		repeat (3) @(posedge clk_sys);
		chk("round_robin", 1'h1, round_robin_en);
		bus(1'h1, 4'h8, 32'h0, q);
		repeat (3) @(posedge clk_sys);
		chk("round_robin", 1'h0, round_robin_en);
		wrap_up();
	end

	// A few thousand cycles suffice.
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		wrap_up();
	end
endmodule // pss_state_eval_tb_top
`default_nettype wire
